// >>> mute_atten_ctrl.sv
// Mute, attenuation, rate window and power-down/reset control.
// Assumes the host pins are asynchronous to ref_clk and the datapath
// samples come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mute_atten_cfg.svh"

module mute_atten_ctrl
    import mute_atten_pkg::*;
#(
    parameter int SAMPLE_W = `SAMPLE_W,
    parameter int TIMEOUT  = `ZC_TIMEOUT
) (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // Host pins.
    input  wire logic                  power_down_reset_n,
    input  wire logic                  global_mute,
    input  wire logic                  frame_clk,
    input  wire logic                  control_latch_strobe,
    input  wire mute_atten_pkg::ctrl_byte_type ctrl_byte,
    input  wire mute_atten_pkg::fmt_sel_type   fmt_sel_pin,
    // Datapath samples.
    input  wire logic [SAMPLE_W-1:0]   sample_left,
    input  wire logic [SAMPLE_W-1:0]   sample_right,
    // Controls to the datapath and analog section.
    output var  mute_atten_pkg::chan_ctrl_type left_out,
    output var  mute_atten_pkg::chan_ctrl_type right_out,
    output var  mute_atten_pkg::fmt_sel_type   fmt_sel,
    output logic                       power_down,
    output logic                       engine_clear,
    output logic                       frame_tick,
    output logic                       rate_ok,
    output logic                       left_pending,
    output logic                       right_pending
);
    import mute_atten_pkg::*;

    localparam logic [`RATE_CNT_W-1:0] MIN_P = `RATE_CNT_W'(`RATE_MIN_DIV);
    localparam logic [`RATE_CNT_W-1:0] MAX_P = `RATE_CNT_W'(`RATE_MAX_DIV);
    localparam logic [`RATE_CNT_W-1:0] SAT_P = '1;

    if (`RATE_MAX_DIV >= (1 << `RATE_CNT_W) - 1) begin : g_bad
        $error("mute_atten_ctrl: rate counter too narrow.");
    end

    // Checks period against the supported frame window.
    function automatic logic in_window(input logic [`RATE_CNT_W-1:0] p);
        in_window = (p >= MIN_P) && (p <= MAX_P);
    endfunction

    // ************************************************************
    // Input synchronisers.
    // ************************************************************

    logic          pd_s1_r, pd_s2_r;
    logic          gm_s1_r, gm_s2_r;
    logic [2:0]    fc_r;
    logic [2:0]    cl_r;
    ctrl_byte_type cb_s1_r, cb_s2_r;
    fmt_sel_type   fs_s1_r, fs_s2_r;

    // Two flops on every pin; a third on the clocks feeds edge detection.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pd_s1_r <= 1'b0;
            pd_s2_r <= 1'b0;
            gm_s1_r <= 1'b0;
            gm_s2_r <= 1'b0;
            fc_r    <= 3'h0;
            cl_r    <= 3'h0;
            cb_s1_r <= '0;
            cb_s2_r <= '0;
            fs_s1_r <= '0;
            fs_s2_r <= '0;
        end else begin
            pd_s1_r <= power_down_reset_n;
            pd_s2_r <= pd_s1_r;
            gm_s1_r <= global_mute;
            gm_s2_r <= gm_s1_r;
            fc_r    <= {fc_r[1:0], frame_clk};
            cl_r    <= {cl_r[1:0], control_latch_strobe};
            cb_s1_r <= ctrl_byte;
            cb_s2_r <= cb_s1_r;
            fs_s1_r <= fmt_sel_pin;
            fs_s2_r <= fs_s1_r;
        end
    end

    logic pd_now;
    logic tick;
    logic latch_edge;

    // Power-down follows the synchronised pin level directly.
    assign pd_now     = !pd_s2_r;
    assign tick       = fc_r[1] && !fc_r[2];
    assign latch_edge = cl_r[1] && !cl_r[2];

    // ************************************************************
    // Power-down and engine clear.
    // ************************************************************

    logic pd_r;

    // Registered power-down; the engine is held clear throughout.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pd_r <= 1'b1;
        end else begin
            pd_r <= pd_now;
        end
    end

    assign power_down   = pd_r;
    assign engine_clear = pd_r;

    // ************************************************************
    // Frame rate window.
    // ************************************************************

    logic [`RATE_CNT_W-1:0] period_r;
    logic                   rate_ok_r;

    // Cycles since the last frame edge, saturating.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            period_r <= '0;
        end else if (pd_r) begin
            period_r <= '0;
        end else if (tick) begin
            period_r <= `RATE_CNT_W'(1);
        end else if (period_r != SAT_P) begin
            period_r <= period_r + 1'b1;
        end
    end

    // Rate judged at each frame edge; a stalled frame clock fails too.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rate_ok_r <= 1'b0;
        end else if (pd_r) begin
            rate_ok_r <= 1'b0;
        end else if (tick) begin
            rate_ok_r <= in_window(period_r);
        end else if (period_r > MAX_P) begin
            rate_ok_r <= 1'b0;
        end
    end

    assign rate_ok    = rate_ok_r;
    assign frame_tick = tick;
    assign fmt_sel    = fs_s2_r;

    // ************************************************************
    // Control byte routing and per-channel updates.
    // ************************************************************

    chan_ctrl_type new_ctrl;
    logic          req_left;
    logic          req_right;
    chan_ctrl_type app_left;
    chan_ctrl_type app_right;

    // Bit 7 picks the channel, bit 6 mute, bits 5..0 attenuation.
    assign new_ctrl  = '{mute:  cb_s2_r.mute,
                         atten: cb_s2_r.attenuation_field};
    assign req_left  = latch_edge && !pd_r &&
                       (cb_s2_r.channel_select_bit != `CHAN_SEL_RIGHT);
    assign req_right = latch_edge && !pd_r &&
                       (cb_s2_r.channel_select_bit == `CHAN_SEL_RIGHT);

    // Left channel tracks its own crossing and timeout.
    chan_update_unit #(
        .SAMPLE_W (SAMPLE_W),
        .TIMEOUT  (TIMEOUT)
    ) u_left (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .engine_clear (pd_r),
        .frame_tick   (tick),
        .sample       (sample_left),
        .req          (req_left),
        .req_ctrl     (new_ctrl),
        .applied      (app_left),
        .pending      (left_pending)
    );

    // Right channel tracks its own crossing and timeout.
    chan_update_unit #(
        .SAMPLE_W (SAMPLE_W),
        .TIMEOUT  (TIMEOUT)
    ) u_right (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .engine_clear (pd_r),
        .frame_tick   (tick),
        .sample       (sample_right),
        .req          (req_right),
        .req_ctrl     (new_ctrl),
        .applied      (app_right),
        .pending      (right_pending)
    );

    // ************************************************************
    // Channel outputs with global mute.
    // ************************************************************

    chan_ctrl_type left_r;
    chan_ctrl_type right_r;

    // Global mute overrides both channels; own mute bit only its own.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            left_r  <= '{mute: `DEF_MUTE, atten: `DEF_ATTEN};
            right_r <= '{mute: `DEF_MUTE, atten: `DEF_ATTEN};
        end else begin
            left_r  <= '{mute:  app_left.mute | gm_s2_r,
                         atten: app_left.atten};
            right_r <= '{mute:  app_right.mute | gm_s2_r,
                         atten: app_right.atten};
        end
    end

    assign left_out  = left_r;
    assign right_out = right_r;

    // ************************************************************
    // Checks.
    // ************************************************************

    sequence s_latch_left;
        latch_edge && !pd_r && !cb_s2_r.channel_select_bit;
    endsequence

    property p_global_mute;
        @(posedge ref_clk) disable iff (!nrst)
        gm_s2_r |=> left_out.mute && right_out.mute;
    endproperty
    a_global_mute: assert property (p_global_mute)
        else $error("Global mute did not mute both channels.");

    property p_left_only;
        @(posedge ref_clk) disable iff (!nrst)
        s_latch_left |=> left_pending && !$rose(right_pending);
    endproperty
    a_left_only: assert property (p_left_only)
        else $error("Left control byte touched the right channel.");

    property p_rate_window;
        @(posedge ref_clk) disable iff (!nrst)
        (tick && !pd_r) |=> rate_ok == in_window($past(period_r));
    endproperty
    a_rate_window: assert property (p_rate_window)
        else $error("Rate flag disagrees with the measured period.");

    property p_reset_defaults;
        @(posedge ref_clk) disable iff (!nrst)
        (pd_r && !gm_s2_r) [*2] |=> left_out == '0 && right_out == '0 &&
                                  !left_pending && !right_pending;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("Channel settings not at defaults during reset.");

    property p_pd_follows_pin;
        @(posedge ref_clk) disable iff (!nrst)
        !pd_s2_r |=> (power_down && engine_clear) ##1 !rate_ok;
    endproperty
    a_pd_follows_pin: assert property (p_pd_follows_pin)
        else $error("Power-down did not follow the reset pin.");

endmodule
`default_nettype wire

// >>> mute_atten_cfg.svh
// Constants for the mute, attenuation and reset control block.
// Assumes inclusion by bare name from the package and the design modules.
//
// What this block does
// - Frame rates up to the master clock divided by 512 are supported.
// - Rates down to master clock over 1024; slower frames are unsupported.
// - Global mute pin high mutes both channels whatever their registers say.
// - A channel register's mute bit mutes only that channel.
// - Attenuation and mute changes wait for a zero crossing, then apply.
// - No zero crossing in 1024 sample periods: the change applies anyway.
// - Power-down/reset low holds power-down; high again means ready to run.
// - During reset every digital engine register is cleared to zero.
// - During reset both channel registers return to their defaults.
// - Format, word-length and emphasis selects may change at any time.
// - Byte MSB first: bit 7 channel, bit 6 mute, bits 5..0 attenuation.
// - Channel registers default to unmuted with attenuation code zero.
// - Latched settings take effect only on a frame edge after the strobe, never between.
`ifndef MUTE_ATTEN_CFG_SVH
`define MUTE_ATTEN_CFG_SVH

// ************************************************************
// Frame rate window, in master clock cycles per frame.
// ************************************************************
`define RATE_MIN_DIV   512
`define RATE_MAX_DIV   1024
`define RATE_CNT_W     11

// ************************************************************
// Zero crossing timeout, in input sample periods.
// ************************************************************
`define ZC_TIMEOUT     1024

// ************************************************************
// Control byte layout and channel defaults.
// ************************************************************
`define CTRL_CHAN_BIT  7
`define CTRL_MUTE_BIT  6
`define CTRL_ATTEN_MSB 5
`define CTRL_ATTEN_LSB 0
`define CHAN_SEL_RIGHT 1'b1
`define DEF_MUTE       1'b0
`define DEF_ATTEN      6'h00

// ************************************************************
// Sample width of the datapath.
// ************************************************************
`define SAMPLE_W       18

`endif

// >>> mute_atten_pkg.sv
// Types shared by the mute, attenuation and reset control modules.
// Assumes the constants header sits in the same folder.
`include "mute_atten_cfg.svh"

package mute_atten_pkg;

    // Settings that one channel applies to its output.
    typedef struct packed {
        logic       mute;
        logic [5:0] atten;
    } chan_ctrl_type;

    // Control byte as it arrives, most significant bit first.
    typedef struct packed {
        logic       channel_select_bit;
        logic       mute;
        logic [5:0] attenuation_field;
    } ctrl_byte_type;

    // Static format selects.
    typedef struct packed {
        logic data_format_select_1;
        logic data_format_select_0;
        logic word_length_select;
        logic emphasis_select;
    } fmt_sel_type;

    // State of a channel's deferred update.
    typedef enum logic {
        st_idle,
        st_pending
    } chan_state_type;

endpackage

// >>> chan_update_unit.sv
// Deferred update of one channel's mute and attenuation.
// Assumes frame_tick is a one-cycle pulse per sample and sample is
// valid on that cycle, both from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mute_atten_cfg.svh"

module chan_update_unit
    import mute_atten_pkg::*;
#(
    parameter int SAMPLE_W = `SAMPLE_W,
    parameter int TIMEOUT  = `ZC_TIMEOUT
) (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic                  engine_clear,
    // Sample timing and waveform.
    input  wire logic                  frame_tick,
    input  wire logic [SAMPLE_W-1:0]   sample,
    // New setting request.
    input  wire logic                  req,
    input  wire mute_atten_pkg::chan_ctrl_type req_ctrl,
    // Applied setting.
    output var  mute_atten_pkg::chan_ctrl_type applied,
    output logic                       pending
);
    import mute_atten_pkg::*;

    localparam int CNT_W = $clog2(TIMEOUT + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT - 1);

    if (TIMEOUT < 2 || SAMPLE_W < 2) begin : g_bad
        $error("chan_update_unit: TIMEOUT and SAMPLE_W must be 2 or more.");
    end

    chan_state_type   state_r;
    chan_ctrl_type    staged_r;
    chan_ctrl_type    applied_r;
    logic [CNT_W-1:0] wait_r;
    logic             prev_neg_r;
    logic             zero_cross;
    logic             fire;

    // ************************************************************
    // Zero crossing and apply decision.
    // ************************************************************

    // A sign change or an exact zero counts as a crossing.
    assign zero_cross = (sample[SAMPLE_W-1] != prev_neg_r) ||
                        (sample == '0);
    assign fire = (state_r == st_pending) && frame_tick && !req &&
                  (zero_cross || wait_r == LAST);

    // Previous sample sign, cleared with the engine.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev_neg_r <= 1'b0;
        end else if (engine_clear) begin
            prev_neg_r <= 1'b0;
        end else if (frame_tick) begin
            prev_neg_r <= sample[SAMPLE_W-1];
        end
    end

    // Pending state; a fresh request restages and restarts the wait.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r  <= st_idle;
            staged_r <= '{mute: `DEF_MUTE, atten: `DEF_ATTEN};
            wait_r   <= '0;
        end else if (engine_clear) begin
            state_r  <= st_idle;
            staged_r <= '{mute: `DEF_MUTE, atten: `DEF_ATTEN};
            wait_r   <= '0;
        end else begin
            case (state_r)
                st_idle: begin
                    if (req) begin
                        state_r  <= st_pending;
                        staged_r <= req_ctrl;
                        wait_r   <= '0;
                    end
                end
                st_pending: begin
                    if (req) begin
                        staged_r <= req_ctrl;
                        wait_r   <= '0;
                    end else if (fire) begin
                        state_r <= st_idle;
                    end else if (frame_tick) begin
                        wait_r <= wait_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // Applied setting, defaults during reset.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            applied_r <= '{mute: `DEF_MUTE, atten: `DEF_ATTEN};
        end else if (engine_clear) begin
            applied_r <= '{mute: `DEF_MUTE, atten: `DEF_ATTEN};
        end else if (fire) begin
            applied_r <= staged_r;
        end
    end

    assign applied = applied_r;
    assign pending = (state_r == st_pending);

    // ************************************************************
    // Checks.
    // ************************************************************

    sequence s_cross_seen;
        pending && frame_tick && zero_cross && !req && !engine_clear;
    endsequence

    property p_apply_on_cross;
        @(posedge ref_clk) disable iff (!nrst)
        s_cross_seen |=> (applied == $past(staged_r)) && !pending;
    endproperty
    a_apply_on_cross: assert property (p_apply_on_cross)
        else $error("Change not applied at zero crossing.");

    property p_timeout_bound;
        @(posedge ref_clk) disable iff (!nrst)
        pending |-> wait_r <= LAST;
    endproperty
    a_timeout_bound: assert property (p_timeout_bound)
        else $error("Pending wait ran past the timeout.");

    property p_timeout_fire;
        @(posedge ref_clk) disable iff (!nrst || engine_clear)
        (pending && frame_tick && !req && wait_r == LAST) |=> !pending;
    endproperty
    a_timeout_fire: assert property (p_timeout_fire)
        else $error("Timeout did not force the change.");

    property p_no_early;
        @(posedge ref_clk) disable iff (!nrst || engine_clear)
        (!frame_tick || !pending) |=> $stable(applied);
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("Setting changed away from a frame edge.");

endmodule
`default_nettype wire

// >>> host_model.sv
// Host side model: frame clock, control byte and latch strobe pins.
// Assumes the bench sets half_per and calls send from its main thread.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import mute_atten_pkg::*;
(
    // Master clock.
    input  wire logic                      ref_clk,
    // Pins towards the device.
    output var  logic                      frame_clk,
    output var  logic                      control_latch_strobe,
    output var  mute_atten_pkg::ctrl_byte_type ctrl_byte
);
    // Half of the frame period, in master clock cycles.
    int half_per = 300;

    // ************************************************
    // Frame clock
    // ************************************************
    // The frame clock runs free at the rate the bench selects.
    initial begin
        frame_clk = 1'b0;
        control_latch_strobe = 1'b0;
        ctrl_byte = 8'h00;
    end
    always begin
        repeat (half_per) @(negedge ref_clk);
        frame_clk = ~frame_clk;
    end

    // ************************************************
    // Control byte
    // ************************************************
    // Holds the byte around the strobe, then lets the lines wander.
    task automatic send(input ctrl_byte_type b);
        @(negedge ref_clk);
        ctrl_byte = b;
        repeat (3) @(negedge ref_clk);
        control_latch_strobe = 1'b1;
        repeat (4) @(negedge ref_clk);
        control_latch_strobe = 1'b0;
        repeat (3) @(negedge ref_clk);
        ctrl_byte = ~b;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the mute, attenuation and reset control.
// Assumes the host model and the design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mute_atten_pkg::*;
    localparam int TMO = 4;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        power_down_reset_n = 1'b1;
    logic        global_mute = 1'b0;
    fmt_sel_type fmt_sel_pin = 4'h0;
    logic [17:0] sample_left = 18'h0_0001;
    logic [17:0] sample_right = 18'h0_0001;
    logic        frame_clk, control_latch_strobe;
    ctrl_byte_type ctrl_byte;
    chan_ctrl_type left_out, right_out;
    fmt_sel_type fmt_sel;
    logic        power_down, engine_clear, frame_tick, rate_ok;
    logic        left_pending, right_pending;
    int          failures = 0;
    int          n_tests = 0;
    int          n_tick = 0;
    int          seed = 32'h4b71e530;
    logic [31:0] r;
    logic [17:0] s;
    logic [6:0]  appl [2];
    logic [6:0]  stg [2];
    bit          pend [2], prev_neg [2], pos_only [2], seen;
    int          cnt [2];

    // ************************************************
    // Clock, partner and device
    // ************************************************
    // The master clock never stops, also during power-down.
    always #12.5 ref_clk = ~ref_clk;
    host_model u_host (.ref_clk(ref_clk), .frame_clk(frame_clk),
        .control_latch_strobe(control_latch_strobe), .ctrl_byte(ctrl_byte));
    mute_atten_ctrl #(.SAMPLE_W(18), .TIMEOUT(TMO)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst),
        .power_down_reset_n(power_down_reset_n), .global_mute(global_mute),
        .frame_clk(frame_clk), .control_latch_strobe(control_latch_strobe),
        .ctrl_byte(ctrl_byte), .fmt_sel_pin(fmt_sel_pin),
        .sample_left(sample_left), .sample_right(sample_right),
        .left_out(left_out), .right_out(right_out), .fmt_sel(fmt_sel),
        .power_down(power_down), .engine_clear(engine_clear),
        .frame_tick(frame_tick), .rate_ok(rate_ok),
        .left_pending(left_pending), .right_pending(right_pending));

    // ************************************************
    // Reference model
    // ************************************************
    // Each frame either applies a pending change or ages it by one.
    always @(posedge frame_clk) begin
        for (int c = 0; c < 2; c++) begin
            s = c ? sample_right : sample_left;
            if (pend[c] && (s == 0 || s[17] != prev_neg[c] ||
                    cnt[c] == TMO - 1)) begin
                appl[c] = stg[c];
                pend[c] = 1'b0;
            end else begin
                cnt[c]++;
            end
            prev_neg[c] = s[17];
        end
    end

    // Outputs are compared mid-frame, then new samples are presented.
    always @(negedge frame_clk) begin
        chk("left_out", {1'b0, appl[0][6] | global_mute, appl[0][5:0]},
            {1'b0, left_out});
        chk("right_out", {1'b0, appl[1][6] | global_mute, appl[1][5:0]},
            {1'b0, right_out});
        chk("pending", {6'h00, pend[1], pend[0]},
            {6'h00, right_pending, left_pending});
        chk("frame_tick", 8'h01, n_tick[7:0]);
        n_tick = 0;
        for (int c = 0; c < 2; c++) begin
            r = $random(seed);
            if (pos_only[c]) r[17] = 1'b0;
            if (r[17:0] == 0) r[0] = 1'b1;
            if (c == 0) sample_left <= r[17:0];
            else sample_right <= r[17:0];
        end
    end

    // Counts frame ticks on the falling edge, away from their launch edge.
    always @(negedge ref_clk) begin
        if (frame_tick === 1'b1) n_tick++;
    end

    // Returns the model to the power-up state of both channels.
    task automatic clr_model();
        for (int c = 0; c < 2; c++) begin
            appl[c] = 7'h00;
            pend[c] = 1'b0;
            prev_neg[c] = 1'b0;
            cnt[c] = 0;
        end
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Sends one control byte and stages it in the model.
    task automatic wr(input logic [7:0] b);
        u_host.send(b);
        stg[b[7]] = b[6:0];
        pend[b[7]] = 1'b1;
        cnt[b[7]] = 0;
    endtask

    // Waits for frame midpoints, then a few clocks more.
    task automatic frames(int n);
        repeat (n) @(negedge frame_clk);
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        int hp [4] = '{255, 256, 512, 513};
        logic [7:0] ok [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
        clr_model();
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        // One frame stands in for the re-lock wait before the first strobe.
        frames(1);
        chk("power_down", 8'h00, {7'h00, power_down});
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            u_host.half_per = hp[i];
            frames(3);
            chk("rate_ok", ok[i], {7'h00, rate_ok});
        end
        u_host.half_per = 300;
        $display("test rate done");
        pos_only[0] = 1'b1;
        wr(8'h2a);
        wr(8'hc5);
        frames(2);
        wr(8'h53);
        frames(TMO + 2);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            pos_only[0] = r[8];
            pos_only[1] = r[9];
            wr(r[7:0]);
            frames(1 + r[10]);
        end
        frames(TMO + 1);
        $display("test channel updates done");
        global_mute = 1'b1;
        wr(8'h0c);
        frames(TMO + 1);
        global_mute = 1'b0;
        frames(1);
        $display("test global mute done");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            fmt_sel_pin = r[3:0];
            repeat (3) @(negedge ref_clk);
            chk("fmt_sel", {4'h0, r[3:0]}, {4'h0, fmt_sel});
        end
        $display("test format selects done");
        pos_only[0] = 1'b1;
        wr(8'h3f);
        wr(8'hff);
        seen = 1'b0;
        power_down_reset_n = 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(negedge ref_clk);
            if (i == 3) power_down_reset_n = 1'b1;
            if (power_down === 1'b1 && engine_clear === 1'b1) seen = 1'b1;
        end
        clr_model();
        chk("power_down seen", 8'h01, {7'h00, seen});
        chk("power_down", 8'h00, {7'h00, power_down});
        frames(1);
        $display("test power-down done");
        summarize();
    end
endmodule
`default_nettype wire
